/* rtl/brc_bank.sv */
`timescale 1ns/1ps
module brc_bank import brc_pkg::*; #(
    parameter logic [2:0] BOOT_SLOT    = SLOT_FIELD,
    parameter int         BOOT_CYC     = BOOT_CYC_DEF,
    parameter int         SS_LONG_CYC  = SS_LONG_DEF,
    parameter int         SS_SHORT_CYC = SS_SHORT_DEF,
    parameter logic [6:0] DEV_ADDR     = DEV_ADDR_DEF
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST_N,
    input  wire logic       HARD_RESET,
    input  wire logic       CTRL_PIN_0,
    input  wire logic       CTRL_PIN_1,
    input  wire logic       CTRL_PIN_2,
    input  wire logic       CTRL_PIN_3,
    input  wire logic       SCL,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE,
    output logic            REG1_ENABLE,
    output logic [5:0]      REG1_VOLTAGE_CODE,
    output logic            REG1_SOFTSTART,
    output logic            REG1_ACTIVE_DSC,
    output logic            REG1_PASSIVE_DSC,
    output logic [3:0]      REG1_PEAK_CODE,
    output logic            REG1_ADAPTIVE_PEAK,
    output logic [1:0]      REG1_ZERO_CROSS,
    output logic            REG1_SWITCH_HALVING,
    output logic            REG1_SLOW_EDGES
);
    brc_bus_if bus ();

    logic [7:0]  shd_r [NREG];
    logic [7:0]  live_r [NREG];
    logic [7:0]  roff;
    logic        hit;
    logic [3:0]  pin_s1, pin_s2, pin_s3;
    logic [1:0]  hr_s;
    logic [31:0] boot_cnt_r;
    logic        en_nxt;
    logic [5:0]  spi_sh_r, spi_code_r, tgt;
    logic [2:0]  spi_cnt_r;
    logic [15:0] ramp_cnt_r;
    logic        tick;
    logic [22:0] ss_cnt_r;
    logic [2:0]  dvs;

    function automatic logic [7:0] rst_val(input int i);
        case (i)
            0:       rst_val = RST_CFG;
            1:       rst_val = RST_VSET;
            2:       rst_val = RST_ISET;
            3:       rst_val = RST_CTR;
            default: rst_val = RST_ALT;
        endcase
    endfunction

    function automatic logic [7:0] wmask(input logic [7:0] r);
        case (r)
            8'h00:   wmask = WM_CFG;
            8'h01,
            8'h02:   wmask = WM_FULL;
            8'h03:   wmask = WM_CTR;
            default: wmask = WM_CODE;
        endcase
    endfunction

    function automatic logic [1:0] pin_pair(input logic [2:0] c, input logic [3:0] p);
        case (c)
            3'h1:    pin_pair = {p[1], p[0]};
            3'h2:    pin_pair = {p[2], p[0]};
            3'h3:    pin_pair = {p[3], p[0]};
            3'h4:    pin_pair = {p[2], p[1]};
            3'h5:    pin_pair = {p[3], p[1]};
            3'h6:    pin_pair = {p[3], p[2]};
            default: pin_pair = 2'h0;
        endcase
    endfunction

    brc_i2c #(.DEV_ADDR(DEV_ADDR)) u_i2c (
        .clk     (CORE_CLK),
        .rst_n   (RST_N),
        .scl_pin (SCL),
        .sda_pin (SDA_I),
        .sda_o   (SDA_O),
        .sda_oe  (SDA_OE),
        .bus     (bus.slave)
    );

    // pin synchronisers; third stage feeds the serial edge detect
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            {pin_s1, pin_s2, pin_s3} <= 12'h0;
            hr_s <= 2'h0;
        end else begin
            pin_s1 <= {CTRL_PIN_3, CTRL_PIN_2, CTRL_PIN_1, CTRL_PIN_0};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            hr_s   <= {hr_s[0], HARD_RESET};
        end
    end

    assign roff = bus.addr - OFS_CFG;
    assign hit  = (bus.addr >= OFS_CFG) && (roff < 8'(NREG));

    // host writes land in shadow copies
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < NREG; i++)
                shd_r[i] <= rst_val(i);
        end else if (bus.wr && hit) begin
            shd_r[roff[2:0]] <= bus.wdata & wmask(roff);
        end
    end

    // shadow reaches the controls only at the end of the transaction
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < NREG; i++)
                live_r[i] <= rst_val(i);
        end else if (bus.stop) begin
            for (int i = 0; i < NREG; i++)
                live_r[i] <= shd_r[i];
        end
    end

    // read data: boot slot is fixed, readback shows the serial code
    always_comb begin
        bus.rdata = 8'h00;
        if (hit) begin
            bus.rdata = shd_r[roff[2:0]];
            if (roff == 8'h00)
                bus.rdata[7:SLOT_LO] = BOOT_SLOT;
        end else if (bus.addr == OFS_SPIRB) begin
            bus.rdata = {2'b00, spi_code_r};
        end
    end

    // boot delay counter
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N)
            boot_cnt_r <= 32'h0;
        else if (boot_cnt_r < 32'(BOOT_CYC))
            boot_cnt_r <= boot_cnt_r + 32'h1;
    end

    // enable source selection
    always_comb begin
        case (BOOT_SLOT)
            SLOT_P0:  en_nxt = 1'b1;
            SLOT_P25: en_nxt = boot_cnt_r >= 32'(BOOT_CYC / 4);
            SLOT_P50: en_nxt = boot_cnt_r >= 32'(BOOT_CYC / 2);
            SLOT_FIELD: begin
                case (live_r[0][EN_LO+:2])
                    EN_ON:   en_nxt = 1'b1;
                    EN_PIN:  en_nxt = |(live_r[3][3:0] & pin_s2);
                    default: en_nxt = 1'b0;
                endcase
                if (boot_cnt_r < 32'(BOOT_CYC))
                    en_nxt = 1'b0;
            end
            default:  en_nxt = 1'b0;
        endcase
    end

    // serial code receiver: pin 0 select low, pin 1 clock, pin 2 data
    assign dvs = live_r[3][DVS_LO+:3];
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            spi_sh_r   <= 6'h00;
            spi_cnt_r  <= 3'h0;
            spi_code_r <= 6'h00;
        end else if (pin_s2[0]) begin
            spi_cnt_r <= 3'h0;
            if (!pin_s3[0] && dvs == DVS_SPI && spi_cnt_r == 3'h6)
                spi_code_r <= spi_sh_r;
        end else if (pin_s2[1] && !pin_s3[1]) begin
            spi_sh_r <= {spi_sh_r[4:0], pin_s2[2]};
            if (spi_cnt_r != 3'h6)
                spi_cnt_r <= spi_cnt_r + 3'h1;
        end
    end

    // voltage target from register, pin pair or serial link
    always_comb begin
        case (dvs)
            DVS_OFF: tgt = live_r[1][5:0];
            DVS_SPI: tgt = spi_code_r;
            default: tgt = live_r[{1'b1, pin_pair(dvs, pin_s2)}][5:0];
        endcase
    end

    // ramp step timer, restarted while no rise is pending
    assign tick = ramp_cnt_r == 16'(RAMP_CYC - 1);
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N || tgt <= REG1_VOLTAGE_CODE || tick)
            ramp_cnt_r <= 16'h0;
        else
            ramp_cnt_r <= ramp_cnt_r + 16'h1;
    end

    // output voltage code: stepped rises, direct falls
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N)
            REG1_VOLTAGE_CODE <= 6'h00;
        else if (tgt < REG1_VOLTAGE_CODE || !live_r[1][RAMP_B])
            REG1_VOLTAGE_CODE <= tgt;
        else if (tgt > REG1_VOLTAGE_CODE && tick)
            REG1_VOLTAGE_CODE <= REG1_VOLTAGE_CODE + 6'h01;
    end

    // enable, soft-start window and discharge requests
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            REG1_ENABLE    <= 1'b0;
            REG1_SOFTSTART <= 1'b0;
            ss_cnt_r       <= 23'h0;
        end else begin
            REG1_ENABLE <= en_nxt;
            if (en_nxt && !REG1_ENABLE) begin
                ss_cnt_r <= live_r[2][SS_B] ? 23'(SS_SHORT_CYC) : 23'(SS_LONG_CYC);
                REG1_SOFTSTART <= 1'b1;
            end else if (!en_nxt) begin
                ss_cnt_r       <= 23'h0;
                REG1_SOFTSTART <= 1'b0;
            end else if (ss_cnt_r != 23'h0) begin
                ss_cnt_r       <= ss_cnt_r - 23'h1;
                REG1_SOFTSTART <= ss_cnt_r != 23'h1;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            REG1_ACTIVE_DSC  <= 1'b0;
            REG1_PASSIVE_DSC <= 1'b0;
        end else begin
            REG1_ACTIVE_DSC  <= hr_s[1] | (live_r[2][ACT_B] & !en_nxt);
            REG1_PASSIVE_DSC <= hr_s[1] | (live_r[0][PSV_B] & !en_nxt);
        end
    end

    // static analog settings
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            REG1_PEAK_CODE      <= RST_ISET[3:0];
            REG1_ADAPTIVE_PEAK  <= RST_ISET[ADPT_B];
            REG1_ZERO_CROSS     <= RST_CFG[ZC_LO+:2];
            REG1_SWITCH_HALVING <= RST_ISET[HALF_B];
            REG1_SLOW_EDGES     <= RST_VSET[SLOW_B];
        end else begin
            REG1_PEAK_CODE      <= live_r[2][3:0];
            REG1_ADAPTIVE_PEAK  <= live_r[2][ADPT_B];
            REG1_ZERO_CROSS     <= live_r[0][ZC_LO+:2];
            REG1_SWITCH_HALVING <= live_r[2][HALF_B];
            REG1_SLOW_EDGES     <= live_r[1][SLOW_B];
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_spi_end;
        pin_s2[0] && !pin_s3[0] && dvs == DVS_SPI && spi_cnt_r == 3'h6;
    endsequence

    a_boot_slot_off: assert property (BOOT_SLOT == SLOT_OFF |-> ##1 !REG1_ENABLE)
        else $error("regulator enabled with boot slot off");
    a_field_enable: assert property (BOOT_SLOT == SLOT_FIELD
        && boot_cnt_r == 32'(BOOT_CYC) && live_r[0][EN_LO+:2] == EN_ON |=> REG1_ENABLE)
        else $error("enable field 01 did not enable");
    a_field_off: assert property (BOOT_SLOT == SLOT_FIELD
        && live_r[0][EN_LO+1] == live_r[0][EN_LO] |=> !REG1_ENABLE)
        else $error("enable field 00 or 11 did not disable");
    a_early_off: assert property (BOOT_SLOT == SLOT_FIELD && boot_cnt_r < 32'(BOOT_CYC)
        |=> !REG1_ENABLE)
        else $error("enabled before boot delay end");
    a_pin_or: assert property (BOOT_SLOT == SLOT_FIELD && boot_cnt_r == 32'(BOOT_CYC)
        && live_r[0][EN_LO+:2] == EN_PIN |=> REG1_ENABLE == $past(|(live_r[3][3:0] & pin_s2)))
        else $error("pin control enable mismatch");
    a_spi_capture: assert property (s_spi_end |=> spi_code_r == $past(spi_sh_r))
        else $error("serial code not captured");
    a_ramp_step: assert property (live_r[1][RAMP_B] && tgt > REG1_VOLTAGE_CODE && !tick
        |=> REG1_VOLTAGE_CODE == $past(REG1_VOLTAGE_CODE))
        else $error("voltage rose without a step tick");
    a_direct_fall: assert property (tgt < REG1_VOLTAGE_CODE |=> REG1_VOLTAGE_CODE == $past(tgt))
        else $error("falling code not applied directly");
    a_soft_start: assert property (en_nxt && !REG1_ENABLE && !live_r[2][SS_B]
        |=> REG1_SOFTSTART && REG1_ENABLE && ss_cnt_r == 23'(SS_LONG_CYC))
        else $error("soft-start window not loaded");
    a_ss_hold: assert property (REG1_SOFTSTART && ss_cnt_r > 23'h1 && en_nxt
        |=> REG1_SOFTSTART)
        else $error("soft-start window ended early");
    a_hard_dsc: assert property (hr_s[1] |=> REG1_ACTIVE_DSC && REG1_PASSIVE_DSC)
        else $error("no discharge during hard reset");
    a_psv_dsc: assert property (!hr_s[1] && !live_r[0][PSV_B] |=> !REG1_PASSIVE_DSC)
        else $error("passive discharge without request");
    a_commit_stop: assert property (!bus.stop |=> live_r[1] == $past(live_r[1]))
        else $error("control changed before transaction end");
endmodule // brc_bank

/* rtl/brc_bus_if.sv */
`timescale 1ns/1ps
interface brc_bus_if;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       wr;
    logic       stop;
    modport slave (output addr, output wdata, output wr, output stop, input rdata);
    modport bank  (input addr, input wdata, input wr, input stop, output rdata);
endinterface

/* rtl/brc_i2c.sv */
`timescale 1ns/1ps
module brc_i2c import brc_pkg::*; #(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    output logic      sda_o,
    output logic      sda_oe,
    brc_bus_if.slave  bus
);
    logic [2:0]  scl_s, sda_s;
    brc_i2c_st_t st_r;
    logic [7:0]  sh_r, ptr_r, wd_r;
    logic [3:0]  cnt_r;
    logic        rw_r, first_r, wr_r, stop_r;
    logic        rise, fall, start, stop;

    // pin synchronisers, third stage only for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
        end else begin
            scl_s <= {scl_s[1:0], scl_pin};
            sda_s <= {sda_s[1:0], sda_pin};
        end
    end
    assign rise  = scl_s[1] & ~scl_s[2];
    assign fall  = ~scl_s[1] & scl_s[2];
    assign start = scl_s[1] & sda_s[2] & ~sda_s[1];
    assign stop  = scl_s[1] & ~sda_s[2] & sda_s[1];

    // byte engine: address, pointer, write data, read data
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= I_IDLE;
            {sh_r, ptr_r, wd_r} <= 24'h0;
            cnt_r <= 4'h0;
            {rw_r, first_r, wr_r, stop_r, sda_oe, sda_o} <= 6'h0;
        end else begin
            wr_r   <= 1'b0;
            stop_r <= stop;
            sda_o  <= 1'b0;
            if (wr_r)
                ptr_r <= ptr_r + 8'h01;
            if (start) begin
                st_r   <= I_ADDR;
                cnt_r  <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stop) begin
                st_r   <= I_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_r)
                    I_ADDR: if (rise) begin
                        sh_r  <= {sh_r[6:0], sda_s[1]};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (fall && cnt_r == 4'h8) begin
                        if (sh_r[7:1] == DEV_ADDR) begin
                            rw_r   <= sh_r[0];
                            sda_oe <= 1'b1;
                            st_r   <= I_AACK;
                        end else begin
                            st_r <= I_IDLE;
                        end
                    end
                    I_AACK: if (fall) begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            sh_r   <= bus.rdata;
                            sda_oe <= ~bus.rdata[7];
                            st_r   <= I_TX;
                        end else begin
                            sda_oe  <= 1'b0;
                            first_r <= 1'b1;
                            st_r    <= I_RX;
                        end
                    end
                    I_RX: if (rise) begin
                        sh_r  <= {sh_r[6:0], sda_s[1]};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (fall && cnt_r == 4'h8) begin
                        sda_oe <= 1'b1;
                        st_r   <= I_WACK;
                        if (first_r) begin
                            ptr_r   <= sh_r;
                            first_r <= 1'b0;
                        end else begin
                            wr_r <= 1'b1;
                            wd_r <= sh_r;
                        end
                    end
                    I_WACK: if (fall) begin
                        sda_oe <= 1'b0;
                        cnt_r  <= 4'h0;
                        st_r   <= I_RX;
                    end
                    I_TX: if (rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end else if (fall) begin
                        if (cnt_r == 4'h8) begin
                            sda_oe <= 1'b0;
                            ptr_r  <= ptr_r + 8'h01;
                            st_r   <= I_MACK;
                        end else begin
                            sh_r   <= {sh_r[6:0], 1'b0};
                            sda_oe <= ~sh_r[6];
                        end
                    end
                    I_MACK: if (rise) begin
                        if (sda_s[1])
                            st_r <= I_IDLE;
                        else
                            cnt_r <= 4'h0;
                    end else if (fall && cnt_r == 4'h0) begin
                        sh_r   <= bus.rdata;
                        sda_oe <= ~bus.rdata[7];
                        st_r   <= I_TX;
                    end
                    default: st_r <= I_IDLE;
                endcase
            end
        end
    end

    assign bus.addr  = ptr_r;
    assign bus.wdata = wd_r;
    assign bus.wr    = wr_r;
    assign bus.stop  = stop_r;
endmodule // brc_i2c

/* rtl/brc_pkg.sv */
package brc_pkg;
    localparam int CLK_NS = 10;
    // register offsets
    localparam logic [7:0] OFS_CFG   = 8'h16;
    localparam logic [7:0] OFS_VSET  = 8'h17;
    localparam logic [7:0] OFS_ISET  = 8'h18;
    localparam logic [7:0] OFS_CTR   = 8'h19;
    localparam logic [7:0] OFS_ALT0  = 8'h1A;
    localparam logic [7:0] OFS_SPIRB = 8'h1E;
    localparam int NREG = 8;
    // reset values and writable bits
    localparam logic [7:0] RST_CFG  = 8'h01;
    localparam logic [7:0] RST_VSET = 8'h40;
    localparam logic [7:0] RST_ISET = 8'h80;
    localparam logic [7:0] RST_CTR  = 8'h01;
    localparam logic [7:0] RST_ALT  = 8'h00;
    localparam logic [7:0] WM_CFG   = 8'h1F;
    localparam logic [7:0] WM_FULL  = 8'hFF;
    localparam logic [7:0] WM_CTR   = 8'h7F;
    localparam logic [7:0] WM_CODE  = 8'h3F;
    // field positions
    localparam int SLOT_LO = 5;
    localparam int EN_LO   = 3;
    localparam int ZC_LO   = 1;
    localparam int PSV_B   = 0;
    localparam int SLOW_B  = 7;
    localparam int RAMP_B  = 6;
    localparam int ADPT_B  = 7;
    localparam int SS_B    = 6;
    localparam int ACT_B   = 5;
    localparam int HALF_B  = 4;
    localparam int DVS_LO  = 4;
    // field codes
    localparam logic [2:0] SLOT_OFF   = 3'h0;
    localparam logic [2:0] SLOT_P0    = 3'h2;
    localparam logic [2:0] SLOT_P25   = 3'h3;
    localparam logic [2:0] SLOT_P50   = 3'h4;
    localparam logic [2:0] SLOT_FIELD = 3'h7;
    localparam logic [1:0] EN_ON      = 2'h1;
    localparam logic [1:0] EN_PIN     = 2'h2;
    localparam logic [2:0] DVS_OFF    = 3'h0;
    localparam logic [2:0] DVS_SPI    = 3'h7;
    // timing
    localparam int RAMP_US      = 20;
    localparam int RAMP_CYC     = (RAMP_US * 1000) / CLK_NS;
    localparam int SS_LONG_MS   = 50;
    localparam int SS_SHORT_MS  = 5;
    localparam int SS_LONG_DEF  = (SS_LONG_MS * 1000000) / CLK_NS;
    localparam int SS_SHORT_DEF = (SS_SHORT_MS * 1000000) / CLK_NS;
    localparam int BOOT_CYC_DEF = 4000;
    localparam logic [6:0] DEV_ADDR_DEF = 7'h28; // arbitrary value
    typedef enum logic [6:0] {
        I_IDLE = 7'b0000001, I_ADDR = 7'b0000010, I_AACK = 7'b0000100,
        I_RX   = 7'b0001000, I_WACK = 7'b0010000, I_TX   = 7'b0100000,
        I_MACK = 7'b1000000
    } brc_i2c_st_t;
endpackage

/* tb/brc_host.sv */
`timescale 1ns/1ps
// two-wire bus master and control pin driver
module brc_host import brc_pkg::*; (
    input  wire logic       clk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_low,
    output logic [3:0]      pins
);
    // bus idle, pins low
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
        pins = 4'h0;
    end
    // wait n falling edges
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    // set all control pins at once
    task automatic pd(input logic [3:0] p);
        pins = p;
    endtask
    // one bit each way, data moves only while the clock is low
    task automatic bt(input logic b, output logic r);
        w(5);
        sda_low = ~b;
        w(15);
        scl = 1'b1;
        w(20);
        r = sda;
        scl = 1'b0;
    endtask
    // byte msb first, then the acknowledge slot
    task automatic by(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
        for (int i = 7; i >= 0; i--) bt(d[i], q[i]);
        bt(a, k);
    endtask
    // start or repeated start
    task automatic st;
        w(5);
        sda_low = 1'b0;
        w(15);
        scl = 1'b1;
        w(20);
        sda_low = 1'b1;
        w(20);
        scl = 1'b0;
    endtask
    // stop, bus released high afterwards
    task automatic sp;
        w(5);
        sda_low = 1'b1;
        w(15);
        scl = 1'b1;
        w(20);
        sda_low = 1'b0;
        w(20);
    endtask
    // pointer then one data byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2;
        st();
        by({DEV_ADDR_DEF, 1'b0}, 1'b1, q, k0);
        by(a, 1'b1, q, k1);
        by(d, 1'b1, q, k2);
        sp();
        ok = ~(k0 | k1 | k2);
    endtask
    // pointer, repeated start, one byte ended by a nack
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k0, k1, k2, k3;
        st();
        by({DEV_ADDR_DEF, 1'b0}, 1'b1, q, k0);
        by(a, 1'b1, q, k1);
        st();
        by({DEV_ADDR_DEF, 1'b1}, 1'b1, q, k2);
        by(8'hFF, 1'b1, d, k3);
        sp();
        ok = ~(k0 | k1 | k2);
    endtask
    // serial voltage frame at 80 ns per bit, data line flipped once released
    task automatic sf(input logic [5:0] v);
        pins[0] = 1'b0;
        for (int i = 5; i >= 0; i--) begin
            pins[2] = v[i];
            w(4);
            pins[1] = 1'b1;
            w(4);
            pins[1] = 1'b0;
        end
        w(4);
        pins[0] = 1'b1;
        pins[2] = ~pins[2];
        w(8);
    endtask
endmodule // brc_host

/* tb/test_brc_bank.sv */
`timescale 1ns/1ps
module test_brc_bank import brc_pkg::*;;
    logic       clk, rst_n, hard, scl, sda_low, sda, sda_o, sda_oe;
    logic       en, ss, act, psv, adp, hlv, slw, ok, pe;
    logic [3:0] pins, pk;
    logic [5:0] vc;
    logic [1:0] zc;
    logic [7:0] mdl [0:255];
    logic [7:0] q, v;
    int         errors, num_checks;
    int         lo [6] = '{0, 0, 0, 1, 1, 2};
    int         hi [6] = '{1, 2, 3, 2, 3, 3};
    // open-drain data wire with pull-up
    assign sda = ~(sda_low | (sda_oe & ~sda_o));
    brc_bank #(.BOOT_CYC(40), .SS_LONG_CYC(200), .SS_SHORT_CYC(20)) brc_bank_i (
        .CORE_CLK(clk), .RST_N(rst_n), .HARD_RESET(hard), .CTRL_PIN_0(pins[0]),
        .CTRL_PIN_1(pins[1]), .CTRL_PIN_2(pins[2]), .CTRL_PIN_3(pins[3]), .SCL(scl),
        .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .REG1_ENABLE(en),
        .REG1_VOLTAGE_CODE(vc), .REG1_SOFTSTART(ss), .REG1_ACTIVE_DSC(act),
        .REG1_PASSIVE_DSC(psv), .REG1_PEAK_CODE(pk), .REG1_ADAPTIVE_PEAK(adp),
        .REG1_ZERO_CROSS(zc), .REG1_SWITCH_HALVING(hlv), .REG1_SLOW_EDGES(slw));
    brc_host brc_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low), .pins(pins));
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        test_done();
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // bus write, model update through the writable-bit masks
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] m;
        m = (a == OFS_CFG) ? WM_CFG : (a == OFS_CTR) ? WM_CTR :
            (a == OFS_VSET || a == OFS_ISET) ? WM_FULL :
            (a >= OFS_ALT0 && a < OFS_SPIRB) ? WM_CODE : 8'h00;
        brc_host_i.wr(a, d, ok);
        chk(ok, 1'b1);
        mdl[a] = (mdl[a] & ~m) | (d & m);
        brc_host_i.w(6);
    endtask
    task automatic rd(input logic [7:0] a);
        brc_host_i.rd(a, q, ok);
        chk({ok, q}, {1'b1, mdl[a]});
    endtask
    // main sequence
    initial begin
        rst_n = 1'b0;
        hard = 1'b0;
        errors = 0;
        num_checks = 0;
        for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
        mdl[OFS_CFG] = {SLOT_FIELD, RST_CFG[4:0]};
        mdl[OFS_VSET] = RST_VSET;
        mdl[OFS_ISET] = RST_ISET;
        mdl[OFS_CTR] = RST_CTR;
        v = 8'($urandom(32'h7CD6));
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        brc_host_i.w(3);
        chk({en, adp, psv, act}, 4'h6);
        for (int a = 8'h16; a <= 8'h1E; a++) rd(8'(a));
        rd(8'h30);
        hard = 1'b1;
        brc_host_i.w(5);
        chk({act, psv}, 2'h3);
        hard = 1'b0;
        brc_host_i.w(5);
        chk({act, psv}, 2'h1);
        $display("test reset done");
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom) & 8'hBF;
            wr(OFS_ISET, v);
            chk({adp, hlv, pk, act}, {v[7], v[4], v[3:0], v[5]});
        end
        rd(OFS_ISET);
        for (int e = 0; e < 4; e++) begin
            wr(OFS_CFG, {3'h0, e[1:0], e[1:0], !e[1]});
            chk({en, ss, psv, act, zc},
                {e == 1, e == 1, !e[1] && e != 1, v[5] && e != 1, e[1:0]});
            if (e == 1) begin
                brc_host_i.w(200);
                chk({en, ss}, 2'h2);
            end
        end
        $display("test enable field done");
        wr(OFS_CFG, {3'h0, EN_PIN, 3'h1});
        for (int i = 0; i < 12; i++) begin
            if (i % 6 == 0) wr(OFS_CTR, i ? 8'h0B : 8'h04);
            brc_host_i.pd(4'($urandom));
            hard = 1'($urandom);
            brc_host_i.w(6);
            pe = |(pins & mdl[OFS_CTR][3:0]);
            chk({en, act, psv},
                {pe, hard | (v[5] & ~pe), hard | (mdl[OFS_CFG][PSV_B] & ~pe)});
        end
        hard = 1'b0;
        $display("test pin enable done");
        wr(OFS_VSET, 8'h05);
        chk(vc, 6'h05);
        wr(OFS_VSET, 8'hC7);
        chk({slw, vc}, 7'h45);
        brc_host_i.w(1000);
        chk(vc, 6'h05);
        brc_host_i.w(1500);
        chk(vc, 6'h06);
        brc_host_i.w(2000);
        chk(vc, 6'h07);
        wr(OFS_VSET, 8'h42);
        chk({slw, vc}, 7'h02);
        wr(OFS_VSET, 8'h02);
        $display("test voltage ramp done");
        for (int p = 0; p < 4; p++) wr(8'(OFS_ALT0 + p), 8'($urandom));
        rd(OFS_ALT0 + 8'h3);
        for (int c = 1; c < 7; c++) begin
            wr(OFS_CTR, 8'(c << 4));
            for (int i = 0; i < 3; i++) begin
                brc_host_i.pd(4'($urandom));
                brc_host_i.w(6);
                chk(vc, mdl[OFS_ALT0 + {pins[hi[c-1]], pins[lo[c-1]]}][5:0]);
            end
        end
        $display("test pin pairs done");
        brc_host_i.pd(4'h1);
        wr(OFS_CTR, 8'h70);
        for (int i = 0; i < 2; i++) begin
            v = 8'($urandom);
            brc_host_i.sf(v[5:0]);
            mdl[OFS_SPIRB] = {2'h0, v[5:0]};
            chk(vc, v[5:0]);
            rd(OFS_SPIRB);
        end
        $display("test serial link done");
        test_done();
    end
endmodule // test_brc_bank
